// ### inc/fmc_pkg.sv
package fmc_pkg;
    // ------------------------------------------------------------
    // Cell timing and mark constants
    // ------------------------------------------------------------
    localparam int FMC_BYTE_BITS = 8;
    localparam int FMC_HALF_CELLS_DEF = 4;
    localparam logic [7:0] FMC_MARK_A1_DATA = 8'hA1;
    localparam logic [7:0] FMC_MARK_A1_CLK = 8'h0A;
    localparam logic [7:0] FMC_MARK_C2_DATA = 8'hC2;
    localparam logic [7:0] FMC_MARK_C2_CLK = 8'h14;
    localparam logic [2:0] FMC_MSB_IDX = 3'h7;
    localparam logic [2:0] FMC_LSB_IDX = 3'h0;

    // Encoding mode
    typedef enum logic [1:0]
    {
        FMC_MODE_FM = 2'h1,
        FMC_MODE_MFM = 2'h2
    } fmc_mode_t;

    // Byte offered to the write path
    typedef struct packed
    {
        logic [7:0] data;
        logic mark;
    } fmc_wbyte_t;

    // Separated read pulses from the drive side
    typedef struct packed
    {
        logic clk_pulse;
        logic data_pulse;
    } fmc_rpulse_t;
endpackage

// ### hdl/fmc_deser.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Read deserializer: collects decoded bits into bytes
// ------------------------------------------------------------
module fmc_deser
    import fmc_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_bit_valid,
    input wire logic i_bit,
    output logic o_byte_valid,
    output logic [7:0] o_byte
);
    typedef struct packed
    {
        logic [7:0] shift;
        logic [2:0] cnt;
        logic [7:0] out;
        logic valid;
    } fmc_dstate_t;

    fmc_dstate_t st_q;
    fmc_dstate_t st_d;

    // MSB first; a byte is out after the eighth bit
    always_comb
    begin
        st_d = st_q;
        st_d.valid = 1'b0;
        if (i_bit_valid)
        begin
            st_d.shift = {st_q.shift[6:0], i_bit};
            st_d.cnt = st_q.cnt + 3'h1;
            if (st_q.cnt == FMC_MSB_IDX)
            begin
                st_d.out = {st_q.shift[6:0], i_bit};
                st_d.valid = 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
            st_q <= '0;
        else if (i_ce)
            st_q <= st_d;
    end

    assign o_byte_valid = st_q.valid;
    assign o_byte = st_q.out;
endmodule

// ### hdl/fmc_codec.sv
`timescale 1ns/100ps
// Contract
// - Every data bit gets a cell of a clock window then a data window.
// - In FM every cell carries a clock-window pulse.
// - In FM the data window pulses only for a one bit.
// - In MFM the data window pulses exactly for a one bit.
// - In MFM a clock pulse appears only for a zero after a zero.
// - MFM cells keep the clock window ahead of the data window.
// - In FM the read clock is taken from the clock-window pulses.
// - Separated clock and data go to a deserializer building bytes.
// - Write pulses leave cell after cell as one serial stream.
// - Address marks drop one MFM clock pulse to break the rule.
// - Mark byte A1 is written with clock pattern 0A.
// - Mark byte C2 is written with clock pattern 14.
module fmc_codec
    import fmc_pkg::*;
#(
    parameter int HALF_CELL_CYCLES = FMC_HALF_CELLS_DEF
)
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_mfm_sel,
    input wire logic i_wr_valid,
    input wire fmc_wbyte_t i_wr_byte,
    input wire logic i_wr_en,
    input wire logic i_rd_clk_pulse,
    input wire logic i_rd_data_pulse,
    output logic o_wr_ready,
    output logic o_wr_pulse,
    output logic o_wr_busy,
    output logic o_rd_valid,
    output logic [7:0] o_rd_byte,
    output logic o_rd_bit_clk
);
    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    if (HALF_CELL_CYCLES < 2 || HALF_CELL_CYCLES > 255)
    begin : g_bad_param
        $error("HALF_CELL_CYCLES out of range");
    end

    localparam logic [7:0] HALF_LAST = 8'(HALF_CELL_CYCLES - 1);

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b01,
        ST_SEND = 2'b10
    } fmc_wstate_t;

    typedef struct packed
    {
        fmc_wstate_t ws;
        fmc_mode_t mode;
        logic [7:0] data;
        logic [7:0] clk_pat;
        logic [2:0] bit_idx;
        logic phase;
        logic [7:0] tick;
        logic prev_bit;
        logic pulse;
        logic ready;
        logic busy;
        logic [2:0] rd_sync_c;
        logic [2:0] rd_sync_d;
        logic rd_lvl_c;
        logic rd_lvl_d;
        logic rd_cell_open;
        logic rd_bit_valid;
        logic rd_bit;
        logic rd_bit_clk;
    } fmc_state_t;

    fmc_state_t st_q;
    fmc_state_t st_d;
    wire logic [7:0] norm_clk;
    logic rd_clk_rise;
    logic rd_data_rise;
    logic deser_valid;
    logic [7:0] deser_byte;

    // ------------------------------------------------------------
    // Write clock pattern
    // ------------------------------------------------------------
    // Normal clock bits for a whole byte, MSB first; bit 7 looks back
    // at the last bit of the byte before
    for (genvar i = 0; i < FMC_BYTE_BITS; i++)
    begin : g_norm_clk
        if (i == FMC_BYTE_BITS - 1)
        begin : g_first
            assign norm_clk[i] = ~i_wr_byte.data[i] & ~st_q.prev_bit;
        end
        else
        begin : g_rest
            assign norm_clk[i] = ~i_wr_byte.data[i] & ~i_wr_byte.data[i+1];
        end
    end

    // Edges count only once sync stages two and three agree; the filtered
    // level rests low after reset like the idle pins, so no false edge
    assign rd_clk_rise = st_q.rd_sync_c[1] & st_q.rd_sync_c[2] &
        ~st_q.rd_lvl_c;
    assign rd_data_rise = st_q.rd_sync_d[1] & st_q.rd_sync_d[2] &
        ~st_q.rd_lvl_d;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        st_d.rd_bit_valid = 1'b0;
        st_d.rd_sync_c = {st_q.rd_sync_c[1:0], i_rd_clk_pulse};
        st_d.rd_sync_d = {st_q.rd_sync_d[1:0], i_rd_data_pulse};
        unique case (st_q.ws)
            ST_IDLE:
            begin
                st_d.pulse = 1'b0;
                st_d.ready = i_wr_en;
                if (i_wr_en && i_wr_valid && st_q.ready)
                begin
                    // Mode latched here only, so no byte mixes rules
                    st_d.mode = i_mfm_sel ? FMC_MODE_MFM :
                        FMC_MODE_FM;
                    st_d.data = i_wr_byte.data;
                    if (!i_mfm_sel)
                        st_d.clk_pat = 8'hFF;
                    else if (i_wr_byte.mark &&
                        i_wr_byte.data == FMC_MARK_A1_DATA)
                        st_d.clk_pat = FMC_MARK_A1_CLK;
                    else if (i_wr_byte.mark &&
                        i_wr_byte.data == FMC_MARK_C2_DATA)
                        st_d.clk_pat = FMC_MARK_C2_CLK;
                    else
                        st_d.clk_pat = norm_clk;
                    st_d.bit_idx = FMC_MSB_IDX;
                    st_d.phase = 1'b0;
                    st_d.tick = '0;
                    st_d.ready = 1'b0;
                    st_d.ws = ST_SEND;
                    st_d.pulse = i_mfm_sel ? norm_clk[FMC_MSB_IDX] : 1'b1;
                    if (i_mfm_sel && i_wr_byte.mark)
                        st_d.pulse = st_d.clk_pat[FMC_MSB_IDX];
                end
            end
            ST_SEND:
            begin
                // Pulse lasts the first cycle of each half cell
                st_d.pulse = 1'b0;
                st_d.tick = st_q.tick + 8'h01;
                if (st_q.tick == HALF_LAST)
                begin
                    st_d.tick = '0;
                    if (!st_q.phase)
                    begin
                        // Data window follows the clock window
                        st_d.phase = 1'b1;
                        st_d.pulse =
                            st_q.data[st_q.bit_idx];
                    end
                    else
                    begin
                        st_d.phase = 1'b0;
                        st_d.prev_bit = st_q.data[st_q.bit_idx];
                        if (st_q.bit_idx == FMC_LSB_IDX)
                        begin
                            st_d.ws = ST_IDLE;
                            st_d.ready = i_wr_en;
                        end
                        else
                        begin
                            st_d.bit_idx = st_q.bit_idx - 3'h1;
                            // FM keeps its clock pulse whatever the pattern
                            st_d.pulse = (st_q.mode == FMC_MODE_FM) |
                                st_q.clk_pat[st_q.bit_idx - 3'h1];
                        end
                    end
                end
            end
            default:
            begin
                st_d.ws = ST_IDLE;
                st_d.pulse = 1'b0;
            end
        endcase
        if (!i_wr_en)
            st_d.prev_bit = 1'b0;
        // Busy is kept in a flop so the output needs no decode
        st_d.busy = (st_d.ws == ST_SEND);
        // Filtered pin levels move only when stages two and three agree
        if (st_q.rd_sync_c[1] == st_q.rd_sync_c[2])
            st_d.rd_lvl_c = st_q.rd_sync_c[2];
        if (st_q.rd_sync_d[1] == st_q.rd_sync_d[2])
            st_d.rd_lvl_d = st_q.rd_sync_d[2];
        // Read side: a clock pulse opens a cell, a data pulse marks a one
        st_d.rd_bit_clk = rd_clk_rise;
        if (rd_clk_rise)
        begin
            if (st_q.rd_cell_open)
            begin
                st_d.rd_bit_valid = 1'b1;
                st_d.rd_bit = 1'b0;
            end
            st_d.rd_cell_open = 1'b1;
        end
        if (rd_data_rise)
        begin
            st_d.rd_bit_valid = 1'b1;
            st_d.rd_bit = 1'b1;
            st_d.rd_cell_open = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            st_q <= '0;
            st_q.ws <= ST_IDLE;
            st_q.mode <= FMC_MODE_FM;
        end
        else if (i_ce)
            st_q <= st_d;
    end

    // ------------------------------------------------------------
    // Byte assembly
    // ------------------------------------------------------------
    fmc_deser u_deser
    (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_bit_valid(st_q.rd_bit_valid),
        .i_bit(st_q.rd_bit),
        .o_byte_valid(deser_valid),
        .o_byte(deser_byte)
    );

    assign o_wr_ready = st_q.ready;
    assign o_wr_pulse = st_q.pulse;
    assign o_wr_busy = st_q.busy;
    assign o_rd_valid = deser_valid;
    assign o_rd_byte = deser_byte;
    assign o_rd_bit_clk = st_q.rd_bit_clk;
endmodule

// ### tb/fmc_codec_props.sv
`timescale 1ns/100ps
// ----------------------------------------
// Codec port checks
// ----------------------------------------
module fmc_codec_props
    import fmc_pkg::*;
#(
    parameter int HALF_CELL_CYCLES = FMC_HALF_CELLS_DEF
)
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_mfm_sel,
    input wire logic i_wr_valid,
    input wire fmc_wbyte_t i_wr_byte,
    input wire logic i_wr_en,
    input wire logic i_rd_clk_pulse,
    input wire logic o_wr_ready,
    input wire logic o_wr_pulse,
    input wire logic o_wr_busy,
    input wire logic o_rd_valid,
    input wire logic o_rd_bit_clk
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    // Byte taken at this edge
    wire acc = i_wr_en && i_wr_valid && o_wr_ready && i_ce;
    take_ready_a: assert property (
        acc |=> !o_wr_ready && o_wr_busy)
        else $error("ready high after take");
    fm_clock_a: assert property (acc && !i_mfm_sel |=> o_wr_pulse)
        else $error("missing fm clock pulse");
    mfm_one_a: assert property (
        acc && i_mfm_sel && i_wr_byte.data[7] |=> !o_wr_pulse)
        else $error("mfm clock before a one");
    pulse_width_a: assert property (o_wr_pulse |=> !o_wr_pulse)
        else $error("write pulse too long");
    pulse_busy_a: assert property (o_wr_pulse |-> o_wr_busy)
        else $error("pulse while idle");
    ready_hold_a: assert property (acc |=> !o_wr_ready [*8])
        else $error("ready back too soon");
    rd_valid_a: assert property (o_rd_valid |=> !o_rd_valid)
        else $error("byte valid too long");
    bit_clk_a: assert property (
        $rose(i_rd_clk_pulse) |-> ##[2:6] o_rd_bit_clk)
        else $error("no read bit clock");
    cover property (acc && i_mfm_sel && i_wr_byte.mark);
    cover property (acc && !i_mfm_sel);
    cover property (o_rd_valid);
endmodule

bind fmc_codec fmc_codec_props #(.HALF_CELL_CYCLES(HALF_CELL_CYCLES)) i_props
    (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_mfm_sel(i_mfm_sel), .i_wr_valid(i_wr_valid), .i_wr_byte(i_wr_byte),
    .i_wr_en(i_wr_en), .i_rd_clk_pulse(i_rd_clk_pulse),
    .o_wr_ready(o_wr_ready), .o_wr_pulse(o_wr_pulse), .o_wr_busy(o_wr_busy),
    .o_rd_valid(o_rd_valid), .o_rd_bit_clk(o_rd_bit_clk));

// ### tb/fmc_drive_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Separated read pulses from the drive
// ----------------------------------------
module fmc_drive_model
(
    input wire logic i_core_clk,
    input wire logic i_slow,
    output logic o_clk_pulse,
    output logic o_data_pulse
);
    // Both lines rest low between pulses
    initial
    begin
        o_clk_pulse = 1'b0;
        o_data_pulse = 1'b0;
    end
    // Wide pulse survives the sync stages; slow gap mimics a slow drive
    task automatic strobe(input logic [1:0] p);
        {o_clk_pulse, o_data_pulse} = p;
        repeat (3) @(negedge i_core_clk);
        {o_clk_pulse, o_data_pulse} = 2'b00;
        repeat (i_slow ? 12 : 4) @(negedge i_core_clk);
    endtask
    // Every cell opens with a clock window, MSB first
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            strobe(2'b10);
            strobe({1'b0, b[i]});
        end
    endtask
endmodule

// ### tb/fmc_codec_tb_top.sv
`timescale 1ns/100ps
// ----------------------------------------
// Codec testbench
// ----------------------------------------
module fmc_codec_tb_top;
    import fmc_pkg::*;
    localparam int H = 2;
    logic i_core_clk = 1'b0;
    logic i_rst, i_mfm_sel, i_wr_valid, i_wr_en, slow, rclk, rdat, prev;
    fmc_wbyte_t i_wr_byte;
    logic o_wr_ready, o_wr_pulse, o_wr_busy, o_rd_valid, o_rd_bit_clk;
    logic [7:0] o_rd_byte;
    logic [15:0] wq[$];
    logic [7:0] rq[$];
    int bad_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int bclk_n = 0;
    logic ce = 1'b1;
    logic [7:0] rd_exp;
    initial forever #10 i_core_clk = ~i_core_clk;
    fmc_codec #(.HALF_CELL_CYCLES(H)) i_dut (.i_core_clk(i_core_clk),
        .i_rst(i_rst), .i_ce(ce), .i_mfm_sel(i_mfm_sel),
        .i_wr_valid(i_wr_valid), .i_wr_byte(i_wr_byte), .i_wr_en(i_wr_en),
        .i_rd_clk_pulse(rclk), .i_rd_data_pulse(rdat),
        .o_wr_ready(o_wr_ready), .o_wr_pulse(o_wr_pulse),
        .o_wr_busy(o_wr_busy), .o_rd_valid(o_rd_valid),
        .o_rd_byte(o_rd_byte), .o_rd_bit_clk(o_rd_bit_clk));
    fmc_drive_model i_drv (.i_core_clk(i_core_clk), .i_slow(slow),
        .o_clk_pulse(rclk), .o_data_pulse(rdat));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        if (bad_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Expected window stream, clock then data per cell, MSB first
    function automatic logic [15:0] enc(logic [7:0] d, logic mk, logic m,
        logic p);
        logic [7:0] c;
        logic [15:0] r;
        for (int i = 7; i >= 0; i--)
        begin
            c[i] = m ? (!d[i] && !p) : 1'b1;
            p = d[i];
        end
        if (m && mk && d == FMC_MARK_A1_DATA)
            c = FMC_MARK_A1_CLK;
        if (m && mk && d == FMC_MARK_C2_DATA)
            c = FMC_MARK_C2_CLK;
        for (int i = 0; i < 8; i++)
            r[2*i+:2] = {c[i], d[i]};
        return r;
    endfunction
    task automatic wr(input logic [7:0] d, input logic mk, input logic m);
        @(negedge i_core_clk);
        while (!o_wr_ready) @(negedge i_core_clk);
        i_mfm_sel = m;
        i_wr_byte = {d, mk};
        i_wr_valid = 1'b1;
        wq.push_back(enc(d, mk, m, prev));
        prev = d[0];
        @(negedge i_core_clk);
        i_wr_valid = 1'b0;
        // A mode change mid-byte must not reach the byte in flight
        i_mfm_sel = 1'($urandom);
    endtask
    // Sample the first cycle of each window after a byte is taken
    initial
    begin
        logic [15:0] got;
        logic [15:0] exp_w;
        forever
        begin
            @(posedge i_core_clk);
            if (i_wr_valid && o_wr_ready && i_wr_en && ce && !i_rst)
            begin
                for (int k = 0; k < 16; k++)
                begin
                    @(negedge i_core_clk);
                    got = {got[14:0], o_wr_pulse};
                    if (k == 0)
                        check(16'(o_wr_busy), 16'h0001);
                    repeat (H - 1) @(negedge i_core_clk);
                end
                exp_w = wq.size() ? wq.pop_front() : ~got;
                check(got, exp_w);
            end
        end
    end
    always @(posedge i_core_clk)
    begin
        if (o_rd_valid)
        begin
            rd_exp = rq.size() ? rq.pop_front() : ~o_rd_byte;
            check({8'h00, o_rd_byte}, {8'h00, rd_exp});
        end
    end
    // Every clock-window pulse on the read pins yields one bit clock
    always @(posedge i_core_clk)
        if (o_rd_bit_clk)
            bclk_n++;
    // Hang guard, well above the expected run length
    always @(posedge i_core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 12000)
        begin
            bad_count++;
            summarize();
        end
    end
    initial
    begin
        i_rst = 1'b1;
        i_mfm_sel = 1'b0;
        i_wr_valid = 1'b0;
        i_wr_en = 1'b1;
        i_wr_byte = '0;
        slow = 1'b0;
        prev = 1'b0;
        void'($urandom(32'h8716));
        repeat (6) @(negedge i_core_clk);
        i_rst = 1'b0;
        wr(8'h00, 1'b0, 1'b0);
        wr(8'hFF, 1'b0, 1'b0);
        wr(8'h00, 1'b0, 1'b1);
        wr(8'hFF, 1'b0, 1'b1);
        wr(8'hA1, 1'b1, 1'b1);
        wr(8'hC2, 1'b1, 1'b1);
        wr(8'hA1, 1'b0, 1'b1);
        repeat (12) wr(8'($urandom), 1'b0, 1'($urandom));
        // Dropping the gate forgets the last bit written
        while (!o_wr_ready) @(negedge i_core_clk);
        i_wr_en = 1'b0;
        prev = 1'b0;
        repeat (3) @(negedge i_core_clk);
        i_wr_en = 1'b1;
        wr(8'h00, 1'b0, 1'b1);
        // A frozen core must not take a byte offered while ready
        while (!o_wr_ready) @(negedge i_core_clk);
        ce = 1'b0;
        i_wr_valid = 1'b1;
        repeat (3) @(negedge i_core_clk);
        check(16'(o_wr_busy), 16'h0000);
        ce = 1'b1;
        i_wr_valid = 1'b0;
        for (int n = 0; n < 8; n++)
        begin
            slow = n[0];
            rq.push_back(n == 0 ? 8'h00 : 8'($urandom));
            i_drv.send_byte(rq[$]);
        end
        i_drv.strobe(2'b10);
        repeat (60) @(negedge i_core_clk);
        check(16'(wq.size() + rq.size()), 16'h0000);
        check(16'(bclk_n), 16'h0041);
        summarize();
    end
endmodule
